// [design/slt_map.svh]
// Purpose: Register map, field positions, reset values, timing counts
// Assumes: 250 MHz clock, 10 ms scan tick
// Notes:   Word index times four gives the byte offset
//
// Functional notes
// RULE1 - Pulse timer output never exceeds programmed time
// RULE2 - Short range 10 ms to 1098,3 s
// RULE3 - Inverted pulse: low on falling edge
// RULE4 - Pulse restart option restarts on change
// RULE5 - Follower copies input, clipped after time
// RULE6 - Follower restart: full-time high, rise restarts
// RULE7 - Rising delay: output high after time
// RULE8 - Inverted delay: output drops after time
// RULE9 - Delay restart option resets on change
// RULE10 - Extended range 0.5 s to 54915 s
// RULE11 - Long delay exposes elapsed time optionally
// RULE12 - Comparator high when elapsed reaches threshold
// RULE13 - Threshold range 0.5 s to 54910 s
// RULE14 - Comparator fed only by long delay
// RULE15 - Delay line drops output after time
// RULE16 - Short gaps still give delayed pulse
// RULE17 - Square wave only while enabled
// RULE18 - Period range 100 ms to 1098,3 s
// RULE19 - Duty from selectors, default fifty percent
// RULE20 - At most one selector, except 10+80
// RULE21 - Whole scan ticks, edge before expiry
`ifndef SLT_MAP_SVH
`define SLT_MAP_SVH

// ****************************************
// Register word indices
// ****************************************
`define SLT_WI_CTRL 6'h00
`define SLT_WI_TM0  6'h01
`define SLT_WI_STAT 6'h09
`define SLT_WI_ELAP 6'h0a
`define SLT_NTM     6'h08

// ****************************************
// Control bits and reset value
// ****************************************
`define SLT_B_CPT_RISE  0
`define SLT_B_CPT_RT    1
`define SLT_B_BF_RT     2
`define SLT_B_DLY_RISE  3
`define SLT_B_DLY_RT    4
`define SLT_B_LDLY_RISE 5
`define SLT_B_LDLY_RT   6
`define SLT_B_LDLY_TVAL 7
`define SLT_CTRL_RST    8'h29

// ****************************************
// Time ranges, in 10 ms or 0.5 s units
// ****************************************
`define SLT_TW        17
`define SLT_SHORT_MIN 17'h00001
`define SLT_SHORT_MAX 17'h1ad06
`define SLT_LONG_MIN  17'h00001
`define SLT_LONG_MAX  17'h1ad06
`define SLT_THR_MAX   17'h1acfc
`define SLT_PER_MIN   17'h0000a

// ****************************************
// Timing
// ****************************************
`define SLT_CLK_NS      4
`define SLT_TICK_NS     10000000
`define SLT_TICK_CYC    (`SLT_TICK_NS / `SLT_CLK_NS)
`define SLT_TICK_MS     10
`define SLT_HALF_MS     500
`define SLT_HALF_TICKS  (`SLT_HALF_MS / `SLT_TICK_MS)
`define SLT_PULSE_TICKS 2'h2

`endif

// [design/slt_pkg.sv]
// Purpose: Types shared by the timer operator block
// Assumes: Nothing
// Notes:   Carriers for operator inputs and outputs
package slt_pkg;

	typedef struct packed {
		logic       cpt;
		logic       bf;
		logic [1:0] dly;
		logic [1:0] dln;
		logic       sq_en;
		logic [6:0] duty;
	} slt_in_s;

	typedef struct packed {
		logic       cpt;
		logic       bf;
		logic [1:0] dly;
		logic       cmp;
		logic [1:0] dln;
		logic       sq;
	} slt_out_s;

endpackage

// [design/slt_timer.sv]
// Purpose: Tick-counting timer used by the pulse, follower, delay and delay line operators
// Assumes: i_tick is a one-cycle enable
// Notes:   Start wins over stop and over expiry
module slt_timer #(
	parameter int W = 17
) (
	input  wire logic         i_clk,    // Clock
	input  wire logic         i_arst_n, // Async reset, low
	input  wire logic         i_tick,   // Time base enable
	input  wire logic         i_start,  // Clear and run
	input  wire logic         i_stop,   // Clear run
	input  wire logic [W-1:0] i_limit,  // Ticks to expiry
	output logic              o_run,    // Timing
	output logic              o_done,   // Expiry pulse
	output logic      [W-1:0] o_count   // Elapsed ticks
);

	wire [W-1:0] cnt_inc = o_count + 1'b1;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_run   <= 1'b0;
			o_done  <= 1'b0;
			o_count <= '0;
		end else begin
			o_done <= 1'b0;
			if (i_start) begin // [RULE21]
				o_run   <= 1'b1;
				o_count <= '0;
			end else if (i_stop) begin
				o_run <= 1'b0;
			end else if (o_run && i_tick) begin // [RULE21]
				o_count <= cnt_inc;
				if (cnt_inc >= i_limit) begin
					o_run  <= 1'b0;
					o_done <= 1'b1;
				end
			end
		end
	end

endmodule

// [design/slt_top.sv]
// Purpose: Timer operators of a safety logic program
// Assumes: Operator inputs synchronous to i_clk
// Notes:   Wishbone classic slave, one wait state
//
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`include "slt_map.svh"

module slt_top
	import slt_pkg::*;
#(
	parameter int TICK_CYC = `SLT_TICK_CYC
) (
	input  wire logic        i_clk,      // 250 MHz clock
	input  wire logic        i_arst_n,   // Async reset, low
	input  wire logic        i_wb_cyc,   // Bus cycle
	input  wire logic        i_wb_stb,   // Strobe
	input  wire logic        i_wb_we,    // Write enable
	input  wire logic [7:0]  i_wb_adr,   // Byte address
	input  wire logic [31:0] i_wb_dat,   // Write data
	input  wire logic [3:0]  i_wb_sel,   // Byte enables
	output logic      [31:0] o_wb_dat,   // Read data
	output logic             o_wb_ack,   // Acknowledge
	input  wire slt_in_s     i_ops,      // Operator inputs
	output slt_out_s         o_ops,      // Operator outputs
	output logic      [16:0] o_elapsed   // Long delay elapsed
);

	localparam int TW = `SLT_TW;
	localparam int NT = 8;
	localparam int DW = $clog2(TICK_CYC);
	localparam logic [TW-1:0] TMIN [NT] = '{
		`SLT_SHORT_MIN, `SLT_SHORT_MIN, `SLT_SHORT_MIN, `SLT_LONG_MIN,
		`SLT_LONG_MIN, `SLT_SHORT_MIN, `SLT_LONG_MIN, `SLT_PER_MIN};
	localparam logic [TW-1:0] TMAX [NT] = '{
		`SLT_SHORT_MAX, `SLT_SHORT_MAX, `SLT_SHORT_MAX, `SLT_LONG_MAX,
		`SLT_THR_MAX, `SLT_SHORT_MAX, `SLT_LONG_MAX, `SLT_SHORT_MAX};

	function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [TW-1:0] clampt(input logic [31:0] v, input logic [TW-1:0] lo,
		input logic [TW-1:0] hi);
		logic [TW-1:0] r;
		r = v[TW-1:0];
		if (v < 32'(lo)) begin
			r = lo;
		end else if (v > 32'(hi)) begin
			r = hi;
		end
		return r;
	endfunction

	// Tenths of the period spent high
	function automatic logic [3:0] duty_tenths(input logic [6:0] s);
		logic [3:0] d;
		case (s)
			7'h00:   d = 4'h5;
			7'h01:   d = 4'h1;
			7'h02:   d = 4'h2;
			7'h04:   d = 4'h3;
			7'h08:   d = 4'h4;
			7'h10:   d = 4'h6;
			7'h20:   d = 4'h7;
			7'h40:   d = 4'h8;
			7'h41:   d = 4'h9;
			default: d = 4'h5;
		endcase
		return d;
	endfunction

	// ****************************************
	// Scan tick dividers
	// ****************************************
	logic [DW-1:0] div_reg;
	logic [5:0]    half_reg;
	logic          tick_reg;
	logic          htick_reg;

	wire div_end  = (div_reg == DW'(TICK_CYC - 1));
	wire half_end = div_end && (half_reg == 6'(`SLT_HALF_TICKS - 1));

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			div_reg   <= '0;
			half_reg  <= '0;
			tick_reg  <= 1'b0;
			htick_reg <= 1'b0;
		end else begin
			div_reg   <= div_end ? '0 : div_reg + 1'b1;
			tick_reg  <= div_end;
			htick_reg <= half_end;
			if (div_end) begin
				half_reg <= half_end ? '0 : half_reg + 1'b1;
			end
		end
	end

	// ****************************************
	// Register file and bus slave
	// ****************************************
	logic [7:0]    ctrl_reg;
	logic [TW-1:0] tm_reg [NT];
	logic [TW-1:0] elap_reg;
	slt_out_s      ops_reg;
	slt_out_s      ops_next;
	logic          ack_reg;
	logic [31:0]   rdat_reg;

	wire [5:0] wi       = i_wb_adr[7:2];
	wire       wb_req   = i_wb_cyc && i_wb_stb && !ack_reg;
	wire       wb_wr    = wb_req && i_wb_we;
	wire       hit_ctl  = (wi == `SLT_WI_CTRL);
	wire       hit_tm   = (wi >= `SLT_WI_TM0) && (wi < `SLT_WI_TM0 + `SLT_NTM);
	wire       hit_stat = (wi == `SLT_WI_STAT);
	wire       hit_elap = (wi == `SLT_WI_ELAP);
	wire [2:0] tsel     = 3'(wi - `SLT_WI_TM0);

	wire [31:0]   ctl_wr = bmerge({24'h0, ctrl_reg}, i_wb_dat, i_wb_sel);
	wire [31:0]   tm_wr  = bmerge(32'(tm_reg[tsel]), i_wb_dat, i_wb_sel);
	wire [TW-1:0] tm_new = clampt(tm_wr, TMIN[tsel], TMAX[tsel]); // [RULE2] [RULE10] [RULE13] [RULE18]

	wire [31:0] rd_next = hit_ctl  ? {24'h0, ctrl_reg} :
	                      hit_tm   ? 32'(tm_reg[tsel]) :
	                      hit_stat ? {24'h0, ops_reg} :
	                      hit_elap ? 32'(elap_reg) : 32'h0;

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ack_reg  <= 1'b0;
			rdat_reg <= 32'h0;
			ctrl_reg <= `SLT_CTRL_RST;
			for (int i = 0; i < NT; i++) begin
				tm_reg[i] <= TMIN[i];
			end
		end else begin
			ack_reg <= wb_req;
			if (wb_req) begin
				rdat_reg <= rd_next;
			end
			if (wb_wr && hit_ctl) begin
				ctrl_reg <= ctl_wr[7:0];
			end
			if (wb_wr && hit_tm) begin
				tm_reg[tsel] <= tm_new;
			end
		end
	end

	assign o_wb_ack  = ack_reg;
	assign o_wb_dat  = rdat_reg;
	assign o_ops     = ops_reg;
	assign o_elapsed = elap_reg;

	// ****************************************
	// Input edges and options
	// ****************************************
	slt_in_s prev_reg;
	slt_in_s rise_s;
	slt_in_s fall_s;

	assign rise_s = i_ops & ~prev_reg;
	assign fall_s = ~i_ops & prev_reg;

	wire cpt_rise = ctrl_reg[`SLT_B_CPT_RISE];
	wire cpt_rt   = ctrl_reg[`SLT_B_CPT_RT];
	wire bf_rt    = ctrl_reg[`SLT_B_BF_RT];
	wire tval     = ctrl_reg[`SLT_B_LDLY_TVAL];
	wire [1:0] d_rm = {ctrl_reg[`SLT_B_LDLY_RISE], ctrl_reg[`SLT_B_DLY_RISE]};
	wire [1:0] d_rt = {ctrl_reg[`SLT_B_LDLY_RT], ctrl_reg[`SLT_B_DLY_RT]};

	// ****************************************
	// Capped pulse timer
	// ****************************************
	logic          c_run;
	logic [TW-1:0] c_cnt;

	wire c_chg   = rise_s.cpt | fall_s.cpt;
	wire c_trig  = cpt_rise ? rise_s.cpt : fall_s.cpt; // [RULE3]
	wire c_start = (c_trig && !c_run) || (cpt_rt && c_chg && c_run); // [RULE4]

	slt_timer #(.W(TW)) u_cpt (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_tick   (tick_reg),
		.i_start  (c_start),
		.i_stop   (1'b0),
		.i_limit  (tm_reg[0]),
		.o_run    (c_run),
		.o_done   (),
		.o_count  (c_cnt)
	);

	// Output follows the timer alone, so input level cannot stretch it
	assign ops_next.cpt = cpt_rise ? c_run : !c_run; // [RULE1] [RULE3]

	// ****************************************
	// Bounded follower
	// ****************************************
	logic b_run;

	slt_timer #(.W(TW)) u_bf (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_tick   (tick_reg),
		.i_start  (rise_s.bf),
		.i_stop   (fall_s.bf && !bf_rt), // [RULE5] [RULE6]
		.i_limit  (tm_reg[1]),
		.o_run    (b_run),
		.o_done   (),
		.o_count  ()
	);

	assign ops_next.bf = bf_rt ? b_run : (i_ops.bf && b_run); // [RULE5] [RULE6]

	// ****************************************
	// Delays and delay lines, short and long
	// ****************************************
	logic [1:0]    d_done;
	logic [1:0]    l_run;
	logic [1:0]    l_done;
	logic [TW-1:0] d_cnt [2];
	logic [1:0]    pls_reg [2];

	for (genvar k = 0; k < 2; k++) begin : g_lane
		wire tk      = (k == 0) ? tick_reg : htick_reg;
		wire d_in    = i_ops.dly[k];
		wire d_chg   = rise_s.dly[k] | fall_s.dly[k];
		wire d_edge  = d_rm[k] ? rise_s.dly[k] : fall_s.dly[k]; // [RULE7] [RULE8]
		wire d_start = d_rt[k] ? d_chg : d_edge; // [RULE9]
		wire d_stop  = d_rm[k] && !d_rt[k] && fall_s.dly[k];
		wire l_start = fall_s.dln[k] && !l_run[k]; // [RULE15]

		slt_timer #(.W(TW)) u_dly (
			.i_clk    (i_clk),
			.i_arst_n (i_arst_n),
			.i_tick   (tk),
			.i_start  (d_start),
			.i_stop   (d_stop),
			.i_limit  (tm_reg[2+k]),
			.o_run    (),
			.o_done   (d_done[k]),
			.o_count  (d_cnt[k])
		);

		slt_timer #(.W(TW)) u_dln (
			.i_clk    (i_clk),
			.i_arst_n (i_arst_n),
			.i_tick   (tk),
			.i_start  (l_start),
			.i_stop   (1'b0),
			.i_limit  (tm_reg[5+k]),
			.o_run    (l_run[k]),
			.o_done   (l_done[k]),
			.o_count  ()
		);

		assign ops_next.dly[k] = d_rm[k] ? (d_in && (ops_reg.dly[k] || d_done[k])) : // [RULE7]
			(rise_s.dly[k] || (ops_reg.dly[k] && !(d_done[k] && !d_in))); // [RULE8]

		// A fall while the line runs is not timed again, so it is merged
		assign ops_next.dln[k] = !l_done[k] && (pls_reg[k] == 2'h0) &&
			(i_ops.dln[k] || ops_reg.dln[k]); // [RULE15] [RULE16]

		always_ff @(posedge i_clk or negedge i_arst_n) begin
			if (!i_arst_n) begin
				pls_reg[k] <= 2'h0;
			end else if (l_done[k]) begin
				pls_reg[k] <= `SLT_PULSE_TICKS; // [RULE16]
			end else if (pls_reg[k] != 2'h0 && tick_reg) begin
				pls_reg[k] <= pls_reg[k] - 1'b1;
			end
		end
	end

	// ****************************************
	// Elapsed value and comparator
	// ****************************************
	wire [TW-1:0] elap_next = tval ? d_cnt[1] : '0; // [RULE11] [RULE14]

	assign ops_next.cmp = (elap_reg >= tm_reg[4]); // [RULE12]

	// ****************************************
	// Square wave source
	// ****************************************
	logic [TW-1:0] ph_reg;

	wire [3:0]    duty  = duty_tenths(i_ops.duty); // [RULE19] [RULE20]
	wire [TW-1:0] per   = tm_reg[7];
	wire          ph_end = (ph_reg >= per - 1'b1);
	wire [20:0]   ph10  = 21'(ph_reg) * 21'h0000a;
	wire [20:0]   pd    = 21'(per) * 21'(duty);

	assign ops_next.sq = i_ops.sq_en && (ph10 < pd); // [RULE17] [RULE19]

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ph_reg <= '0;
		end else if (!i_ops.sq_en) begin
			ph_reg <= '0; // [RULE17]
		end else if (tick_reg) begin
			ph_reg <= ph_end ? '0 : ph_reg + 1'b1;
		end
	end

	// ****************************************
	// Operator state
	// ****************************************
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			prev_reg <= '0;
			ops_reg  <= '0;
			elap_reg <= '0;
		end else begin
			prev_reg <= i_ops;
			ops_reg  <= ops_next;
			elap_reg <= elap_next;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	chk_cpt_cap_time: assert property (c_run && $stable(tm_reg[0]) |-> c_cnt < tm_reg[0]) // [RULE1]
		else $error("pulse timer ran past its time");
	chk_short_range: assert property (tm_reg[0] >= `SLT_SHORT_MIN && tm_reg[0] <= `SLT_SHORT_MAX) // [RULE2]
		else $error("short time out of range");
	chk_cpt_inv_low: assert property (!cpt_rise && !cpt_rt && fall_s.cpt && !c_run |-> ##2 !ops_reg.cpt) // [RULE3]
		else $error("inverted pulse did not go low");
	chk_cpt_restart: assert property (cpt_rt && c_run && c_chg |=> c_run && c_cnt == '0) // [RULE4]
		else $error("pulse timer not restarted");
	chk_bf_follow: assert property (!bf_rt && !i_ops.bf |=> !ops_reg.bf) // [RULE5]
		else $error("follower high with input low");
	// A tick in the same cycle may be the expiry, which legally ends the run
	chk_bf_hold: assert property (bf_rt && b_run && fall_s.bf && !tick_reg |=> b_run) // [RULE6]
		else $error("follower timer cleared on fall");
	chk_dly_rise_in: assert property (d_rm[0] && ops_reg.dly[0] |-> $past(i_ops.dly[0])) // [RULE7]
		else $error("delay high without input");
	chk_dly_inv_set: assert property (!d_rm[0] && rise_s.dly[0] |=> ops_reg.dly[0]) // [RULE8]
		else $error("inverted delay not set on rise");
	chk_dly_restart: assert property (d_rt[1] && (rise_s.dly[1] || fall_s.dly[1]) |=> d_cnt[1] == '0) // [RULE9]
		else $error("long delay not restarted");
	chk_long_range: assert property (tm_reg[3] >= `SLT_LONG_MIN && tm_reg[3] <= `SLT_LONG_MAX) // [RULE10]
		else $error("long time out of range");
	chk_elap_gate: assert property (!$past(tval) |-> elap_reg == '0) // [RULE11]
		else $error("elapsed shown while disabled");
	chk_cmp_thresh: assert property (ops_reg.cmp == $past(elap_reg >= tm_reg[4])) // [RULE12]
		else $error("comparator wrong");
	chk_thr_range: assert property (tm_reg[4] <= `SLT_THR_MAX && tm_reg[4] != '0) // [RULE13]
		else $error("threshold out of range");
	chk_dln_pulse: assert property (l_done[0] |-> ##1 !ops_reg.dln[0] [*2]) // [RULE16]
		else $error("delay line pulse too short");
	chk_sq_off: assert property (!i_ops.sq_en |=> !ops_reg.sq) // [RULE17]
		else $error("square wave while disabled");
	chk_per_range: assert property (tm_reg[7] >= `SLT_PER_MIN && tm_reg[7] <= `SLT_SHORT_MAX) // [RULE18]
		else $error("period out of range");

	cov_cpt_pulse: cover property ($rose(ops_reg.cpt) ##[1:300] $fell(ops_reg.cpt));
	cov_sq_toggle: cover property ($rose(ops_reg.sq) ##[1:300] $fell(ops_reg.sq));
	cov_dln_gap: cover property (l_done[0] && i_ops.dln[0]);

endmodule

// [tb/slt_upstream.sv]
// Purpose: Upstream logic operators that feed the timer block
// Assumes: Bench changes wanted levels just after a rising edge
// Notes:   Registered, as a logic scan would present them
module slt_upstream
	import slt_pkg::*;
(
	input  wire logic    i_clk,    // Clock
	input  wire logic    i_arst_n, // Async reset, low
	input  wire slt_in_s i_want,   // Levels asked for
	output slt_in_s      o_ops     // Levels presented
);
	timeunit 1ns;
	timeprecision 1ps;
	logic    duty_ok;
	slt_in_s legal;
	// Upstream never shows two selectors, bar the 10 and 80 pair
	assign duty_ok = $onehot0(i_want.duty) || (i_want.duty == 7'h41);
	always_comb begin
		legal = i_want;
		if (!duty_ok) begin
			legal.duty = 7'h00;
		end
	end
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_ops <= '0;
		end else begin
			o_ops <= legal;
		end
	end
endmodule

// [tb/slt_top_bench.sv]
// Purpose: Self-checking bench for the timer operator block
// Assumes: TICK_CYC of 10: short tick 10 cycles, long tick 500
// Notes:   Timing windows allow one tick of phase slack
module slt_top_bench
	import slt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 10;
	logic        i_clk = 1'b0;
	logic        i_arst_n = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic [31:0] o_wb_dat;
	logic        o_wb_ack;
	slt_in_s     want = '0;
	slt_in_s     ops_in;
	slt_out_s    o_ops;
	logic [7:0]  ov;
	logic [16:0] o_elapsed;
	int          miscompares = 0;
	int          total_checks = 0;
	int          n;
	logic [6:0]  dc [9] = '{7'h00, 7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20, 7'h40, 7'h41};
	int          pc [9] = '{50, 10, 20, 30, 40, 60, 70, 80, 90};
	assign ov = o_ops;
	always #2 i_clk = ~i_clk;

	slt_upstream u_up (
		.i_clk   (i_clk),
		.i_arst_n(i_arst_n),
		.i_want  (want),
		.o_ops   (ops_in)
	);
	slt_top #(.TICK_CYC(TK)) u_dut (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_wb_cyc (cyc),
		.i_wb_stb (stb),
		.i_wb_we  (we),
		.i_wb_adr (adr),
		.i_wb_dat (wdat),
		.i_wb_sel (4'hf),
		.o_wb_dat (o_wb_dat),
		.o_wb_ack (o_wb_ack),
		.i_ops    (ops_in),
		.o_ops    (o_ops),
		.o_elapsed(o_elapsed)
	);

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string w);
		total_checks++;
		if (s !== e) begin
			miscompares++;
			$display("MISMATCH t=%0t %s: %h not %h", $time, w, s, e);
		end
	endtask
	task automatic chkb(input logic s, input logic e, input string w);
		chk({31'h0, s}, {31'h0, e}, w);
	endtask
	task automatic chk_rng(input int v, input int lo, input int hi, input string w);
		chkb(v >= lo && v <= hi, 1'b1, w);
	endtask
	task automatic cyc_n(input int k);
		repeat (k) @(posedge i_clk);
	endtask
	// Count cycles with output bit b high; each edge samples the settled value
	task automatic hi_cnt(input int b, input int span, output int h);
		h = 0;
		repeat (span) begin
			@(posedge i_clk);
			if ($isunknown(ov[b])) begin
				chkb(1'b1, 1'b0, "unknown output");
			end
			h += ov[b];
		end
	endtask
	// Classic cycle: hold everything until ack is sampled, then release
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge i_clk);
			k++;
		end while (o_wb_ack !== 1'b1);
		rdat = o_wb_dat;
		chk(k, 2, "ack wait");
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic wait_el(input logic [16:0] v);
		int k = 0;
		while (o_elapsed !== v && k < 1600) begin
			@(posedge i_clk);
			k++;
		end
		chk({15'h0, o_elapsed}, {15'h0, v}, "elapsed");
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		wb(0, 8'h00, 0);
		chk(rdat, 32'h29, "ctrl rst");
		wb(0, 8'h04, 0);
		chk(rdat, 32'h1, "time rst");
		wb(0, 8'h3c, 0);
		chk(rdat, 32'h0, "unmapped");
		wb(1, 8'h04, 32'h0);
		wb(0, 8'h04, 0);
		chk(rdat, 32'h1, "short min");
		wb(1, 8'h04, 32'h1ffff);
		wb(0, 8'h04, 0);
		chk(rdat, 32'h1ad06, "short max");
		wb(1, 8'h10, 32'h1ffff);
		wb(0, 8'h10, 0);
		chk(rdat, 32'h1ad06, "long max");
		wb(1, 8'h14, 32'h1ffff);
		wb(0, 8'h14, 0);
		chk(rdat, 32'h1acfc, "thr max");
		wb(1, 8'h20, 32'h1);
		wb(0, 8'h20, 0);
		chk(rdat, 32'ha, "period min");
		wb(1, 8'h24, 32'hffff);
		wb(0, 8'h24, 0);
		chk(rdat, 32'h0, "status ro");
		wb(1, 8'h04, 32'h3);
		wb(1, 8'h08, 32'h3);
		wb(1, 8'h0c, 32'h5);
		wb(1, 8'h18, 32'h3);
		$display("register test done");
	endtask
	task automatic t_pulse();
		int h1;
		want.cpt <= 1'b1;
		hi_cnt(7, 80, n);
		chk_rng(n, 2 * TK, 3 * TK + 3, "pulse len");
		chkb(ov[7], 1'b0, "pulse cap");
		want.cpt <= 1'b0;
		cyc_n(40);
		wb(1, 8'h00, 32'h2b);
		want.cpt <= 1'b1;
		hi_cnt(7, 15, h1);
		want.cpt <= 1'b0;
		hi_cnt(7, 60, n);
		chk_rng(h1 + n, 30, 50, "pulse restart");
		wb(1, 8'h00, 32'h28);
		want.cpt <= 1'b1;
		cyc_n(50);
		want.cpt <= 1'b0;
		hi_cnt(7, 60, n);
		chk_rng(60 - n, 2 * TK, 3 * TK + 3, "pulse low");
		wb(1, 8'h00, 32'h29);
		$display("pulse test done");
	endtask
	task automatic t_follow();
		want.bf <= 1'b1;
		hi_cnt(6, 60, n);
		chk_rng(n, 18, 34, "follow len");
		chkb(ov[6], 1'b0, "follow clip");
		want.bf <= 1'b0;
		cyc_n(4);
		want.bf <= 1'b1;
		cyc_n(5);
		chkb(ov[6], 1'b1, "follow rise");
		want.bf <= 1'b0;
		cyc_n(40);
		wb(1, 8'h00, 32'h2d);
		want.bf <= 1'b1;
		cyc_n(5);
		want.bf <= 1'b0;
		hi_cnt(6, 60, n);
		chk_rng(n, 12, 30, "follow hold");
		wb(1, 8'h00, 32'h29);
		$display("follower test done");
	endtask
	task automatic t_delay();
		want.dly[0] <= 1'b1;
		cyc_n(12);
		chkb(ov[4], 1'b0, "dly early");
		cyc_n(48);
		chkb(ov[4], 1'b1, "dly late");
		want.dly[0] <= 1'b0;
		cyc_n(20);
		wb(1, 8'h00, 32'h21);
		want.dly[0] <= 1'b1;
		cyc_n(4);
		chkb(ov[4], 1'b1, "inv rise");
		want.dly[0] <= 1'b0;
		cyc_n(12);
		chkb(ov[4], 1'b1, "inv early");
		cyc_n(48);
		chkb(ov[4], 1'b0, "inv late");
		wb(1, 8'h00, 32'h31);
		want.dly[0] <= 1'b1;
		cyc_n(4);
		want.dly[0] <= 1'b0;
		cyc_n(20);
		want.dly[0] <= 1'b1;
		cyc_n(2);
		want.dly[0] <= 1'b0;
		cyc_n(34);
		chkb(ov[4], 1'b1, "dly restart");
		cyc_n(60);
		chkb(ov[4], 1'b0, "dly expire");
		wb(1, 8'h00, 32'h29);
		$display("delay test done");
	endtask
	task automatic t_long();
		wb(1, 8'h10, 32'h4);
		wb(1, 8'h14, 32'h3);
		want.dly[1] <= 1'b1;
		cyc_n(600);
		chk({15'h0, o_elapsed}, 32'h0, "elapsed off");
		want.dly[1] <= 1'b0;
		cyc_n(5);
		wb(1, 8'h00, 32'ha9);
		want.dly[1] <= 1'b1;
		wait_el(17'h2);
		cyc_n(3);
		chkb(o_ops.cmp, 1'b0, "cmp below");
		chkb(o_ops.dly[1], 1'b0, "long early");
		wait_el(17'h3);
		cyc_n(3);
		chkb(o_ops.cmp, 1'b1, "cmp at thr");
		n = 3;
		while (o_ops.dly[1] !== 1'b1 && n < 700) begin
			@(posedge i_clk);
			n++;
		end
		chk_rng(n, 490, 520, "long tick");
		want.dly[1] <= 1'b0;
		wb(1, 8'h00, 32'h29);
		$display("long delay test done");
	endtask
	task automatic t_dline();
		// Two long ticks keep the long line busy past the early check
		wb(1, 8'h1c, 32'h2);
		want.dln <= 2'h3;
		cyc_n(5);
		chkb(ov[1], 1'b1, "dln follow");
		want.dln[0] <= 1'b0;
		cyc_n(5);
		want.dln[0] <= 1'b1;
		cyc_n(10);
		chkb(ov[1], 1'b1, "dln shifted");
		hi_cnt(1, 60, n);
		chk_rng(60 - n, 18, 24, "dln pulse");
		want.dln <= 2'h0;
		cyc_n(12);
		chkb(ov[1], 1'b1, "dln early");
		cyc_n(30);
		chkb(ov[1], 1'b0, "dln late");
		chkb(ov[2], 1'b1, "ldln early");
		cyc_n(1070);
		chkb(ov[2], 1'b0, "ldln late");
		$display("delay line test done");
	endtask
	task automatic t_square();
		want.duty <= 7'h01;
		hi_cnt(0, 200, n);
		chk(n, 0, "sq off");
		for (int i = 0; i < 9; i++) begin
			want.duty <= dc[i];
			want.sq_en <= 1'b1;
			cyc_n(200);
			hi_cnt(0, 1000, n);
			chk_rng(n, pc[i] * 10 - 25, pc[i] * 10 + 25, "duty");
		end
		want.sq_en <= 1'b0;
		cyc_n(5);
		hi_cnt(0, 300, n);
		chk(n, 0, "sq stop");
		$display("square test done");
	endtask

	// ****************************************
	// Run control
	// ****************************************
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		cyc_n(8);
		i_arst_n <= 1'b1;
		cyc_n(1);
		t_regs();
		t_pulse();
		t_follow();
		t_delay();
		t_long();
		t_dline();
		t_square();
		end_of_test();
	end
	// Run needs about 16000 cycles; two and a half times that means a hang
	initial begin
		cyc_n(40000);
		miscompares++;
		end_of_test();
	end
endmodule
